// File: rtl/mmd_portal_pkg.sv
// Purpose: shared constants for the indirect register portal and its PMA/PMD register pair
// Assumes: 16-bit management registers selected by a 5-bit register number
// Notes:   every offset, field position and 16-bit reset value lives here; one-bit flag resets are literals in the RTL
package mmd_portal_pkg;

  // management register numbers of the two portal registers
  localparam logic [4:0] CTRL_OFFSET = 5'h0d;
  localparam logic [4:0] DATA_OFFSET = 5'h0e;

  // widths
  localparam int MGMT_ADDR_WIDTH = 5;
  localparam int DATA_WIDTH      = 16;
  localparam int MAX_DEVICES     = 32;

  // operation field encodings in the portal control register
  typedef enum logic [1:0] {
    OP_ADDRESS     = 2'h0,
    OP_DATA_HOLD   = 2'h1,
    OP_DATA_INC_RW = 2'h2,
    OP_DATA_INC_WR = 2'h3
  } portal_op_t;

  // field positions of the portal control register
  localparam int OP_MSB  = 15;
  localparam int OP_LSB  = 14;
  localparam int DEV_MSB = 4;
  localparam int DEV_LSB = 0;

  // reset values
  localparam logic [15:0] CTRL_RESET     = 16'h0000;
  localparam logic [15:0] ADDR_RESET     = 16'h0000;
  localparam logic [15:0] RDATA_RESET    = 16'h0000;
  localparam logic [15:0] PMA_CTRL_RESET = 16'h0000;
  localparam logic [15:0] READ_ZERO      = 16'h0000;
  localparam logic [15:0] ADDR_STEP      = 16'h0001;

  // PMA/PMD device and its two registers
  localparam logic [4:0]  PMA_DEVICE       = 5'h01;
  localparam logic [15:0] PMA_CTRL_INDEX   = 16'h0000;
  localparam logic [15:0] PMA_STATUS_INDEX = 16'h0001;

  // PMA/PMD bit positions
  localparam int LPI_ENABLE_BIT  = 12;
  localparam int LPI_ENTERED_BIT = 8;
  localparam int LPI_NOW_BIT     = 3;

endpackage

// File: rtl/pma_lpi_regs.sv
// Purpose: PMA/PMD control and status registers behind the indirect portal
// Assumes: lpi_now comes from PMA logic on the same clock
// Notes:   status reads combinationally; the caller registers the read data
`timescale 1ns/1ns
`default_nettype none

module pma_lpi_regs (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // access from the portal
  input  wire logic        acc_wr,
  input  wire logic        acc_rd,
  input  wire logic        acc_status,
  input  wire logic [15:0] acc_wdata,
  // PMA/PMD state
  input  wire logic        lpi_now,
  // register views
  output logic      [15:0] ctrl_value,
  output logic      [15:0] status_value,
  output logic             lpi_enable
);

  typedef struct packed {
    logic [15:0] ctrl;
    logic        entered;
  } pma_state_t;

  pma_state_t state;
  pma_state_t next_state;

  always_comb begin
    next_state = state;
    // other bits are reserved but writable, so the whole word is stored
    if (acc_wr && !acc_status) begin
      next_state.ctrl = acc_wdata;
    end
    // set beats the clear of a status read in the same cycle
    if (acc_rd && acc_status) begin
      next_state.entered = 1'b0;
    end
    if (lpi_now) begin
      next_state.entered = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state.ctrl    <= mmd_portal_pkg::PMA_CTRL_RESET;
      state.entered <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  always_comb begin
    status_value = mmd_portal_pkg::READ_ZERO;
    status_value[mmd_portal_pkg::LPI_ENTERED_BIT] = state.entered;
    status_value[mmd_portal_pkg::LPI_NOW_BIT]     = lpi_now;
  end

  assign ctrl_value = state.ctrl;
  assign lpi_enable = state.ctrl[mmd_portal_pkg::LPI_ENABLE_BIT];

endmodule

`default_nettype wire

// File: rtl/mmd_indirect_access_portal.sv
// Purpose: indirect register portal reached through management registers 0xd and 0xe
// Assumes: management frames already decoded to one-cycle read and write strobes on clk
// Notes:   one stored register address per device; unmapped targets read zero
//
// Notes on behaviour
// - up to 32 devices, each 65,536 registers of 16 bits, via two registers
// - control bits 4:0 pick the device for later data-register accesses
// - control bits 15:14 pick the operation done through the data register
// - operation 00: data register reads and writes the stored register address
// - nonzero operation: data register moves contents of the addressed register
// - operation 01: stored address never changes on data accesses
// - operation 10: stored address advances after every data read and write
// - operation 11: stored address advances after data writes, not reads
// - PMA/PMD control bit 12 is a writable LPI enable, reset zero
// - PMA/PMD status bit 8 latches high on LPI entry until read
// - PMA/PMD status bit 3 shows live LPI state, not latched
`timescale 1ns/1ns
`default_nettype none

module mmd_indirect_access_portal #(
  parameter int DEVICE_COUNT = 32
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // management register port
  input  wire logic [4:0]  mgmt_addr,
  input  wire logic        mgmt_wr,
  input  wire logic        mgmt_rd,
  input  wire logic [15:0] mgmt_wdata,
  output logic      [15:0] mgmt_rdata,
  output logic             mgmt_rvalid,
  // PMA/PMD low-power idle
  input  wire logic        lpi_now,
  output logic             lpi_enable
);

  // device field is five bits wide, so more than 32 devices cannot be named
  if (DEVICE_COUNT < 2 || DEVICE_COUNT > mmd_portal_pkg::MAX_DEVICES) begin : g_bad_count
    $error("DEVICE_COUNT must lie between 2 and 32");
  end

  typedef struct packed {
    logic [15:0]                   ctrl;
    logic [DEVICE_COUNT-1:0][15:0] ind_addr;
    logic [15:0]                   rdata;
    logic                          rvalid;
  } portal_state_t;

  portal_state_t state;
  portal_state_t next_state;

  // decoded strobes; a write in the same cycle as a read wins
  logic                       wr_take;
  logic                       rd_take;
  logic                       ctrl_hit;
  logic                       data_hit;

  // portal control fields
  mmd_portal_pkg::portal_op_t op;
  logic [4:0]                 dev;
  logic                       dev_ok;
  logic [15:0]                cur_addr;
  logic                       data_mode;

  // PMA/PMD target decode
  logic                       pma_hit;
  logic                       pma_status;
  logic                       pma_wr;
  logic                       pma_rd;
  logic [15:0]                pma_ctrl_value;
  logic [15:0]                pma_status_value;

  // post increment decision
  logic                       step;
  logic [15:0]                read_word;

  // per-device stored address entries
  logic                          addr_wr;
  logic [DEVICE_COUNT-1:0]       entry_sel;
  logic [DEVICE_COUNT-1:0][15:0] entry_next;

  assign wr_take  = mgmt_wr;
  assign rd_take  = mgmt_rd && !mgmt_wr;
  assign ctrl_hit = (mgmt_addr == mmd_portal_pkg::CTRL_OFFSET);
  assign data_hit = (mgmt_addr == mmd_portal_pkg::DATA_OFFSET);

  assign op  = mmd_portal_pkg::portal_op_t'(
                 state.ctrl[mmd_portal_pkg::OP_MSB:mmd_portal_pkg::OP_LSB]);
  assign dev = state.ctrl[mmd_portal_pkg::DEV_MSB:mmd_portal_pkg::DEV_LSB];

  // devices numbered DEVICE_COUNT and above keep no address and read zero
  assign dev_ok    = ({1'b0, dev} < 6'(DEVICE_COUNT));
  assign data_mode = (op != mmd_portal_pkg::OP_ADDRESS);

  always_comb begin
    cur_addr = mmd_portal_pkg::ADDR_RESET;
    for (int i = 0; i < DEVICE_COUNT; i++) begin
      if (dev == 5'(i)) begin
        cur_addr = state.ind_addr[i];
      end
    end
  end

  // only the PMA/PMD control and status words are backed in this block
  assign pma_status = (cur_addr == mmd_portal_pkg::PMA_STATUS_INDEX);
  assign pma_hit    = data_mode && (dev == mmd_portal_pkg::PMA_DEVICE)
                      && (pma_status || cur_addr == mmd_portal_pkg::PMA_CTRL_INDEX);
  assign pma_wr     = wr_take && data_hit && pma_hit;
  assign pma_rd     = rd_take && data_hit && pma_hit;

  pma_lpi_regs u_pma_regs (
    .clk          (clk),
    .sys_rst      (sys_rst),
    .acc_wr       (pma_wr),
    .acc_rd       (pma_rd),
    .acc_status   (pma_status),
    .acc_wdata    (mgmt_wdata),
    .lpi_now      (lpi_now),
    .ctrl_value   (pma_ctrl_value),
    .status_value (pma_status_value),
    .lpi_enable   (lpi_enable)
  );

  // post increment per operation field
  always_comb begin
    step = 1'b0;
    if (data_hit && dev_ok) begin
      unique case (op)
        mmd_portal_pkg::OP_ADDRESS:     step = 1'b0;
        mmd_portal_pkg::OP_DATA_HOLD:   step = 1'b0;
        mmd_portal_pkg::OP_DATA_INC_RW: step = wr_take || rd_take;
        mmd_portal_pkg::OP_DATA_INC_WR: step = wr_take;
      endcase
    end
  end

  assign addr_wr = wr_take && data_hit && !data_mode;

  // one entry per device: load in address mode, otherwise post increment
  for (genvar i = 0; i < DEVICE_COUNT; i++) begin : g_entry
    logic [15:0] bumped;
    // 16-bit sum wraps from 0xffff to zero on its own
    assign bumped        = state.ind_addr[i] + mmd_portal_pkg::ADDR_STEP;
    assign entry_sel[i]  = (dev == 5'(i));
    assign entry_next[i] = (entry_sel[i] && addr_wr) ? mgmt_wdata :
                           (entry_sel[i] && step)    ? bumped     : state.ind_addr[i];
  end

  // word returned for a read of the management register under mgmt_addr
  always_comb begin
    read_word = mmd_portal_pkg::READ_ZERO;
    if (ctrl_hit) begin
      read_word = state.ctrl;
    end else if (data_hit) begin
      if (!data_mode) begin
        read_word = cur_addr;
      end else if (pma_hit) begin
        read_word = pma_status ? pma_status_value : pma_ctrl_value;
      end
    end
  end

  always_comb begin
    next_state        = state;
    next_state.rvalid = 1'b0;

    if (rd_take) begin
      next_state.rdata  = read_word;
      next_state.rvalid = 1'b1;
    end

    // whole word is stored, reserved bits included, since they are writable
    if (wr_take && ctrl_hit) begin
      next_state.ctrl = mgmt_wdata;
    end

    next_state.ind_addr = entry_next;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state.ctrl   <= mmd_portal_pkg::CTRL_RESET;
      state.rdata  <= mmd_portal_pkg::RDATA_RESET;
      state.rvalid <= 1'b0;
      for (int i = 0; i < DEVICE_COUNT; i++) begin
        state.ind_addr[i] <= mmd_portal_pkg::ADDR_RESET;
      end
    end else begin
      state <= next_state;
    end
  end

  assign mgmt_rdata  = state.rdata;
  assign mgmt_rvalid = state.rvalid;

endmodule

`default_nettype wire

// File: verif/mgmt_host.sv
// Purpose: management host model issuing portal register strobes
// Assumes: one-cycle strobes, read answer one cycle after the strobe
// Notes:   idle address and data lines carry the inverse of the last value
`timescale 1ns/1ns
`default_nettype none
module mgmt_host (
  // clock and answer
  input  wire logic        clk,
  input  wire logic [15:0] mgmt_rdata,
  input  wire logic        mgmt_rvalid,
  // strobes
  output logic      [4:0]  mgmt_addr,
  output logic             mgmt_wr,
  output logic             mgmt_rd,
  output logic      [15:0] mgmt_wdata
);
  initial begin
    mgmt_addr = 5'h00;
    mgmt_wr = 1'b0;
    mgmt_rd = 1'b0;
    mgmt_wdata = 16'h0000;
  end
  task automatic access(input logic wr, input logic [4:0] a, input logic [15:0] d,
                        output logic [15:0] q, output logic ok);
    @(posedge clk);
    #2;
    mgmt_addr = a;
    mgmt_wdata = d;
    mgmt_wr = wr;
    mgmt_rd = !wr;
    @(posedge clk);
    #2;
    mgmt_wr = 1'b0;
    mgmt_rd = 1'b0;
    mgmt_addr = ~a;
    mgmt_wdata = ~d;
    q = mgmt_rdata;
    ok = mgmt_rvalid;
  endtask
  task automatic write_reg(input logic [4:0] a, input logic [15:0] d);
    logic [15:0] q;
    logic ok;
    access(1'b1, a, d, q, ok);
  endtask
  // address mode first, then register number, then data mode
  task automatic set_target(input logic [4:0] dev, input logic [15:0] ra, input logic [1:0] op);
    write_reg(mmd_portal_pkg::CTRL_OFFSET, {11'h000, dev});
    write_reg(mmd_portal_pkg::DATA_OFFSET, ra);
    write_reg(mmd_portal_pkg::CTRL_OFFSET, {op, 9'h000, dev});
  endtask
endmodule
`default_nettype wire

// File: verif/mmd_portal_asserts.sv
// Purpose: port-level checks of the indirect register portal
// Assumes: one clock domain, synchronous reset
// Notes:   keeps its own copy of the control register
`timescale 1ns/1ns
`default_nettype none
module mmd_portal_asserts #(
  parameter int DEVICE_COUNT = 32
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [4:0]  mgmt_addr,
  input  wire logic        mgmt_wr,
  input  wire logic        mgmt_rd,
  input  wire logic [15:0] mgmt_wdata,
  input  wire logic [15:0] mgmt_rdata,
  input  wire logic        mgmt_rvalid,
  input  wire logic        lpi_now,
  input  wire logic        lpi_enable
);
  logic [15:0] ctrl_copy;
  logic        rd_take;
  assign rd_take = mgmt_rd && !mgmt_wr;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_copy <= 16'h0000;
    end else if (mgmt_wr && mgmt_addr == mmd_portal_pkg::CTRL_OFFSET) begin
      ctrl_copy <= mgmt_wdata;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  read_answer_a: assert property (rd_take |=> mgmt_rvalid)
    else $error("read not answered");
  rvalid_cause_a: assert property (mgmt_rvalid |-> $past(rd_take))
    else $error("stray rvalid");
  rdata_hold_a: assert property (!mgmt_rvalid |-> $stable(mgmt_rdata))
    else $error("rdata moved");
  unmapped_zero_a: assert property (rd_take && mgmt_addr != 5'h0d
    && mgmt_addr != 5'h0e |=> mgmt_rdata == 16'h0000) else $error("unmapped read not zero");
  ctrl_readback_a: assert property (rd_take && mgmt_addr == 5'h0d
    |=> mgmt_rdata == $past(ctrl_copy)) else $error("control readback");
  addr_readback_a: assert property (mgmt_wr && mgmt_addr == 5'h0e
    && ctrl_copy[15:14] == 2'h0 && ctrl_copy[4:0] < DEVICE_COUNT ##2 rd_take
    && mgmt_addr == 5'h0e |=> mgmt_rdata == $past(mgmt_wdata, 3)) else $error("address readback");
  lpi_en_change_a: assert property ($changed(lpi_enable) |-> $past(mgmt_wr)
    && $past(mgmt_addr) == 5'h0e && lpi_enable == $past(mgmt_wdata[12]))
    else $error("lpi enable moved");
  reset_clear_a: assert property ($fell(sys_rst) |-> !lpi_enable && !mgmt_rvalid
    && mgmt_rdata == 16'h0000) else $error("reset values");
  cover property (rd_take && mgmt_addr == 5'h0e && ctrl_copy[15:14] == 2'h2);
  cover property (mgmt_wr && mgmt_addr == 5'h0e && ctrl_copy[15:14] == 2'h3);
  cover property ($rose(lpi_enable));
  cover property (lpi_now && rd_take && mgmt_addr == 5'h0e && ctrl_copy[15:14] != 2'h0);
endmodule
bind mmd_indirect_access_portal mmd_portal_asserts #(.DEVICE_COUNT(DEVICE_COUNT)) u_asserts (
  .clk(clk), .sys_rst(sys_rst), .mgmt_addr(mgmt_addr), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd),
  .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid),
  .lpi_now(lpi_now), .lpi_enable(lpi_enable));
`default_nettype wire

// File: verif/mmd_indirect_access_portal_bench.sv
// Purpose: self-checking bench of the indirect register portal
// Assumes: host model drives strobes, bench drives lpi_now
// Notes:   seed fixed so random values repeat
`timescale 1ns/1ns
`default_nettype none
module mmd_indirect_access_portal_bench;
  logic        clk;
  logic        sys_rst;
  logic        lpi_now;
  logic        lpi_enable;
  logic        mgmt_wr;
  logic        mgmt_rd;
  logic        mgmt_rvalid;
  logic [4:0]  mgmt_addr;
  logic [15:0] mgmt_wdata;
  logic [15:0] mgmt_rdata;
  logic [15:0] v;
  int          errors;
  int          tests_run;
  mmd_indirect_access_portal #(.DEVICE_COUNT(32)) u_dut (.clk(clk), .sys_rst(sys_rst),
    .mgmt_addr(mgmt_addr), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata),
    .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid), .lpi_now(lpi_now),
    .lpi_enable(lpi_enable));
  mgmt_host u_host (.clk(clk), .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid),
    .mgmt_addr(mgmt_addr), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata));
  function automatic logic [15:0] status_word(input logic entered, input logic now);
    return {7'h00, entered, 4'h0, now, 3'h0};
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd_check(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] q;
    logic ok;
    u_host.access(1'b0, a, 16'h0000, q, ok);
    check({15'h0000, ok}, 16'h0001);
    check(q, exp);
  endtask
  task automatic lpi_set(input logic lvl);
    @(posedge clk);
    #2;
    lpi_now = lvl;
  endtask
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #800000;
    errors++;
    give_verdict();
  end
  initial begin
    sys_rst = 1'b1;
    lpi_now = 1'b0;
    errors = 0;
    tests_run = 0;
    v = 16'($urandom(74006));
    repeat (20) @(posedge clk);
    #2;
    sys_rst = 1'b0;
    check({15'h0000, lpi_enable}, 16'h0000);
    rd_check(5'h0d, mmd_portal_pkg::CTRL_RESET);
    rd_check(5'h0e, mmd_portal_pkg::ADDR_RESET);
    rd_check(5'($urandom_range(12, 0)), 16'h0000);
    $display("reset values done");
    repeat (6) begin
      v = 16'($urandom);
      u_host.write_reg(5'h0d, v);
      rd_check(5'h0d, v);
      u_host.write_reg(5'h0d, {2'h0, v[13:0]});
      v = 16'($urandom);
      u_host.write_reg(5'h0e, v);
      rd_check(5'h0e, v);
    end
    $display("random control and address done");
    u_host.set_target(5'h01, 16'h0000, 2'h1);
    v = 16'($urandom);
    u_host.write_reg(5'h0e, v);
    check({15'h0000, lpi_enable}, {15'h0000, v[12]});
    rd_check(5'h0e, v);
    rd_check(5'h0e, v);
    // flip the enable so both levels are seen whatever the seed gives
    v[12] = ~v[12];
    u_host.write_reg(5'h0e, v);
    check({15'h0000, lpi_enable}, {15'h0000, v[12]});
    rd_check(5'h0e, v);
    $display("hold mode done");
    u_host.set_target(5'h01, 16'hffff, 2'h2);
    rd_check(5'h0e, 16'h0000);
    rd_check(5'h0e, v);
    rd_check(5'h0e, status_word(1'b0, 1'b0));
    u_host.write_reg(5'h0d, 16'h0001);
    rd_check(5'h0e, 16'h0002);
    $display("increment on all done");
    u_host.set_target(5'h01, 16'h0000, 2'h3);
    rd_check(5'h0e, v);
    rd_check(5'h0e, v);
    u_host.write_reg(5'h0e, v);
    rd_check(5'h0e, status_word(1'b0, 1'b0));
    u_host.write_reg(5'h0d, 16'h0001);
    rd_check(5'h0e, 16'h0001);
    $display("increment on writes done");
    u_host.set_target(5'h01, 16'h0001, 2'h1);
    lpi_set(1'b1);
    lpi_set(1'b0);
    rd_check(5'h0e, status_word(1'b1, 1'b0));
    rd_check(5'h0e, status_word(1'b0, 1'b0));
    lpi_set(1'b1);
    rd_check(5'h0e, status_word(1'b1, 1'b1));
    lpi_set(1'b0);
    rd_check(5'h0e, status_word(1'b1, 1'b0));
    rd_check(5'h0e, status_word(1'b0, 1'b0));
    $display("low power idle flags done");
    give_verdict();
  end
endmodule
`default_nettype wire
